// ===== hdl/sia_pkg.sv
// sia_pkg: shared constants and state records of the interrupt aggregator.
// assumes a single 25 MHz clock and synchronous active-high reset.
package sia_pkg;
   localparam int CLK_MHZ = 25;
   localparam int CODE_W = 4;
   localparam int MON_W = 8;
   // cause register layout
   localparam int CAUSE_W = 8;
   localparam int BIT_EXT_FLAG = 0;
   localparam int BIT_CODE_FLAG = 2;
   localparam logic [7:0] CAUSE_CLR_ON_READ = 8'hFA;
   localparam logic [7:0] CAUSE_RESET = 8'h00;
   localparam logic [7:0] MASK_ALL = 8'hFF;
   // extended cause register layout
   localparam int EXT_W = 8;
   localparam int BIT_EXT_MONITOR = 2;
   // change bits in the channel-0 view, above the code
   localparam int BIT_CH1_CHG = CODE_W;
   localparam int BIT_CH0_CHG = CODE_W + 1;
   localparam int BIT_SQ_CHG = CODE_W + 2;
   // monitor status layout
   localparam int MON_ST_W = 4;
   localparam int BIT_MON_BYTE = 0;
   localparam int BIT_MON_END = 1;
   localparam int BIT_MON_ACK = 2;
   localparam int BIT_MON_ABORT = 3;

   typedef struct packed {
      logic [CODE_W-1:0] last_in;
      logic [CODE_W-1:0] shown;
      logic [CODE_W-1:0] spare;
      logic unread;
      logic spare_valid;
      logic announced;
   } sia_buf_type;

   typedef struct packed {
      logic tx_valid_prev;
      logic in_packet;
      logic rx_ack_bit;
      logic [MON_W-1:0] data;
      logic [MON_ST_W-1:0] status;
   } sia_mon_type;

   typedef struct packed {
      logic [CAUSE_W-1:0] cause;
      logic [CAUSE_W-1:0] cause_view;
      logic [EXT_W-1:0] ext;
      logic [EXT_W-1:0] ext_view;
      logic sq_chg;
      logic ch0_chg;
      logic ch1_chg;
      logic dcl_prev;
      logic int_oe;
   } sia_core_type;
endpackage

// ===== hdl/sia_code_buf.sv
// sia_code_buf: two-entry receive buffer for one received code.
// assumes the code input is synchronous and i_rd pulses once per read.
module sia_code_buf
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [sia_pkg::CODE_W-1:0] i_code,
   input wire logic i_enable,
   input wire logic i_rd,
   output logic [sia_pkg::CODE_W-1:0] o_code,
   output logic o_new
);
   sia_pkg::sia_buf_type s;
   sia_pkg::sia_buf_type next_s;
   logic changed;

   always_comb
   begin
      next_s = s;
      o_new = 1'b0;
      changed = (i_code != s.last_in);
      next_s.last_in = i_code;
      if (i_rd)
      begin
         next_s.unread = 1'b0;
         next_s.announced = 1'b0;
         if (s.spare_valid)
         begin
            // unread spare moves up at once and is a fresh event
            next_s.shown = s.spare;
            next_s.unread = 1'b1;
            next_s.spare_valid = 1'b0;
         end
      end
      if (changed)
      begin
         if (!next_s.unread)
         begin
            next_s.shown = i_code;
            next_s.unread = 1'b1;
         end
         else
         begin
            // spare always keeps the newest code
            next_s.spare = i_code;
            next_s.spare_valid = 1'b1;
         end
      end
      // announcement waits for the enable
      if (s.unread && !s.announced && i_enable)
      begin
         o_new = 1'b1;
         next_s.announced = 1'b1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         s <= '0;
      else
         s <= next_s;
   end

   assign o_code = s.shown;

   a_no_overwrite: assert property (@(posedge i_clk) disable iff (i_rst)
      (s.unread && !i_rd) |=> $stable(s.shown))
      else $error("unread code was overwritten");
   a_spare_loads: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_rd && s.spare_valid && !(i_code != s.last_in)) |=> (s.shown == $past(s.spare)))
      else $error("spare code not loaded after read");
endmodule

// ===== hdl/sia_monitor.sv
// sia_monitor: monitor channel byte capture and its status flags.
// assumes the valid bit and event inputs are synchronous levels/pulses.
module sia_monitor
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_rx_enable,
   input wire logic i_hs_control,
   input wire logic i_tx_enable,
   input wire logic i_tx_valid_bit,
   input wire logic [sia_pkg::MON_W-1:0] i_byte,
   input wire logic i_end,
   input wire logic i_acked,
   input wire logic i_aborted,
   input wire logic i_rd,
   output logic [sia_pkg::MON_W-1:0] o_data,
   output logic [sia_pkg::MON_ST_W-1:0] o_status,
   output logic o_rx_ack_bit,
   output logic o_evt
);
   sia_pkg::sia_mon_type s;
   sia_pkg::sia_mon_type next_s;
   logic byte_in;
   logic [sia_pkg::MON_ST_W-1:0] set;

   always_comb
   begin
      next_s = s;
      set = '0;
      byte_in = s.tx_valid_prev && !i_tx_valid_bit;
      next_s.tx_valid_prev = i_tx_valid_bit;
      if (byte_in && i_rx_enable && (i_hs_control || !s.in_packet))
      begin
         set[sia_pkg::BIT_MON_BYTE] = 1'b1;
         next_s.data = i_byte;
      end
      if (byte_in)
         next_s.in_packet = 1'b1;
      if (i_end)
         next_s.in_packet = 1'b0;
      set[sia_pkg::BIT_MON_END] = i_end && i_rx_enable && i_hs_control;
      set[sia_pkg::BIT_MON_ACK] = i_acked && i_tx_enable;
      set[sia_pkg::BIT_MON_ABORT] = i_aborted && i_tx_enable;
      // handshake bit answers each byte while control and receive enable are on
      if (!i_hs_control)
         next_s.rx_ack_bit = 1'b1;
      else if (byte_in && i_rx_enable)
         next_s.rx_ack_bit = 1'b0;
      else if (i_tx_valid_bit)
         next_s.rx_ack_bit = 1'b1;
      next_s.status = (i_rd ? '0 : s.status) | set;
      o_evt = |set;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         s <= '0;
      else
         s <= next_s;
   end

   assign o_data = s.data;
   assign o_status = s.status;
   assign o_rx_ack_bit = s.rx_ack_bit;

   a_mdr_needs_enable: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(s.status[sia_pkg::BIT_MON_BYTE]) |-> $past(i_rx_enable))
      else $error("byte flag without receive enable");
   a_ack_needs_enable: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(s.status[sia_pkg::BIT_MON_ACK]) |-> $past(i_tx_enable))
      else $error("ack flag without transmit enable");
endmodule

// ===== hdl/sia_core.sv
// sia_core: interrupt aggregator, cause/extended/code registers, request line.
// assumes reads arrive as one-cycle strobes after the host sampled the view outputs.
// Operation
// - six direct sources; bit 0 flags eight extended sources.
// - cause read clears all bits except extended and code flags.
// - code flag clears only on channel-0 code register read.
// - extended read clears extended register and extended flag.
// - request drops once cause register is empty.
// - masked bits hidden from reads, kept pending until unmasked.
// - cause read leaves masked pending events intact.
// - extended and code flags set even masked, without request.
// - code flag from S/Q, channel 0, channel 1 in terminal mode.
// - disabled S/Q or channel-1 changes wait for enable.
// - three change bits live in channel-0 view, cleared on its read.
// - new code never overwrites unread one; pending loads after read.
// - two-entry buffer: first then most recent code returned.
// - monitor receive flags gated by two enables, transmit flags by one.
// - no byte flag without receive enable; first byte only without handshake.
// - with both enables each byte stored, flagged and acknowledged.
// - request level-active, stays asserted while any unmasked source remains.
// - all-ones mask drops request; restored mask reasserts it.
// - request changes only on data clock rising edge.
// - reads releasing last source drop request at next data clock rising edge.
// - request open-drain active low, driven only when active.
module sia_core
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_data_clock_line,
   input wire logic [7:0] i_mask,
   input wire logic [5:0] i_src_evt,
   input wire logic [7:0] i_ext_evt,
   input wire logic i_cause_rd,
   input wire logic i_ext_rd,
   input wire logic i_ch0_rd,
   input wire logic i_sq_rd,
   input wire logic i_ch1_rd,
   input wire logic [3:0] i_sq_code,
   input wire logic [3:0] i_ch0_code,
   input wire logic [3:0] i_ch1_code,
   input wire logic i_terminal_mode,
   input wire logic i_sq_change_enable,
   input wire logic i_ch1_change_enable,
   input wire logic i_mon_rx_enable,
   input wire logic i_mon_hs_control,
   input wire logic i_mon_tx_enable,
   input wire logic i_mon_tx_valid_bit,
   input wire logic [7:0] i_mon_byte,
   input wire logic i_mon_end,
   input wire logic i_mon_acked,
   input wire logic i_mon_aborted,
   input wire logic i_mon_rd,
   output logic [7:0] o_cause_status_reg,
   output logic [7:0] o_extended_cause_reg,
   output logic [6:0] o_code_receive_reg0,
   output logic [3:0] o_sq_receive_reg,
   output logic [3:0] o_code_receive_reg1,
   output logic [7:0] o_mon_data,
   output logic [3:0] o_mon_status,
   output logic o_monitor_rx_ack_bit,
   output logic o_int_req_n_o,
   output logic o_int_req_n_oe
);
   sia_pkg::sia_core_type s;
   sia_pkg::sia_core_type next_s;
   logic sq_new;
   logic ch0_new;
   logic ch1_new;
   logic mon_evt;
   logic dcl_rise;
   logic pending;
   logic code_set;
   logic [7:0] cause_set;
   logic [7:0] cause_clr;
   logic [7:0] ext_set;
   logic [7:0] ext_clr;

   sia_code_buf u_sq_buf
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_code(i_sq_code),
      .i_enable(i_sq_change_enable),
      .i_rd(i_sq_rd),
      .o_code(o_sq_receive_reg),
      .o_new(sq_new)
   );

   sia_code_buf u_ch0_buf
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_code(i_ch0_code),
      .i_enable(1'b1),
      .i_rd(i_ch0_rd),
      .o_code(o_code_receive_reg0[3:0]),
      .o_new(ch0_new)
   );

   // channel 1 only counts in terminal mode
   sia_code_buf u_ch1_buf
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_code(i_ch1_code),
      .i_enable(i_ch1_change_enable && i_terminal_mode),
      .i_rd(i_ch1_rd),
      .o_code(o_code_receive_reg1),
      .o_new(ch1_new)
   );

   sia_monitor u_monitor
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_rx_enable(i_mon_rx_enable),
      .i_hs_control(i_mon_hs_control),
      .i_tx_enable(i_mon_tx_enable),
      .i_tx_valid_bit(i_mon_tx_valid_bit),
      .i_byte(i_mon_byte),
      .i_end(i_mon_end),
      .i_acked(i_mon_acked),
      .i_aborted(i_mon_aborted),
      .i_rd(i_mon_rd),
      .o_data(o_mon_data),
      .o_status(o_mon_status),
      .o_rx_ack_bit(o_monitor_rx_ack_bit),
      .o_evt(mon_evt)
   );

   always_comb
   begin
      next_s = s;
      dcl_rise = i_data_clock_line && !s.dcl_prev;
      next_s.dcl_prev = i_data_clock_line;
      code_set = sq_new || ch0_new || ch1_new;
      // extended register, whole shown content clears on read
      ext_set = i_ext_evt;
      ext_set[sia_pkg::BIT_EXT_MONITOR] = i_ext_evt[sia_pkg::BIT_EXT_MONITOR] || mon_evt;
      ext_clr = i_ext_rd ? s.ext_view : 8'h00;
      next_s.ext = (s.ext & ~ext_clr) | ext_set;
      next_s.ext_view = next_s.ext;
      // cause register; only bits the host saw are cleared
      cause_set = {i_src_evt[5:1], code_set, i_src_evt[0], |ext_set};
      cause_clr = i_cause_rd ? (s.cause_view & sia_pkg::CAUSE_CLR_ON_READ) : 8'h00;
      if (i_ext_rd)
         cause_clr[sia_pkg::BIT_EXT_FLAG] = 1'b1;
      if (i_ch0_rd)
         cause_clr[sia_pkg::BIT_CODE_FLAG] = 1'b1;
      next_s.cause = (s.cause & ~cause_clr) | cause_set;
      next_s.cause_view = next_s.cause & ~i_mask;
      // change bits, set wins over the read clear
      next_s.sq_chg = (s.sq_chg && !i_ch0_rd) || sq_new;
      next_s.ch0_chg = (s.ch0_chg && !i_ch0_rd) || ch0_new;
      next_s.ch1_chg = (s.ch1_chg && !i_ch0_rd) || ch1_new;
      // masked flags never raise the request
      pending = |(s.cause & ~i_mask);
      // request level only moves on a data clock rising edge
      if (dcl_rise)
         next_s.int_oe = pending;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         s <= '0;
      else
         s <= next_s;
   end

   assign o_cause_status_reg = s.cause_view;
   assign o_extended_cause_reg = s.ext_view;
   assign o_code_receive_reg0[6:4] = {s.sq_chg, s.ch0_chg, s.ch1_chg};
   // open drain: low only while a request is active
   assign o_int_req_n_o = 1'b0;
   assign o_int_req_n_oe = s.int_oe;

   sequence dcl_edge_seq;
      dcl_rise;
   endsequence

   sequence idle_edge_seq;
      dcl_rise && !pending;
   endsequence

   a_int_edge_only: assert property (@(posedge i_clk) disable iff (i_rst)
      !dcl_rise |=> $stable(s.int_oe))
      else $error("request moved without data clock edge");
   a_int_release: assert property (@(posedge i_clk) disable iff (i_rst)
      idle_edge_seq |=> !o_int_req_n_oe)
      else $error("request not released with nothing pending");
   a_int_holds: assert property (@(posedge i_clk) disable iff (i_rst)
      (dcl_edge_seq and pending) |=> o_int_req_n_oe)
      else $error("request not asserted with pending source");
   a_mask_all: assert property (@(posedge i_clk) disable iff (i_rst)
      (dcl_rise && i_mask == sia_pkg::MASK_ALL) |=> !o_int_req_n_oe)
      else $error("all-ones mask left request active");
   a_ext_flag_set: assert property (@(posedge i_clk) disable iff (i_rst)
      (|i_ext_evt) |=> s.cause[sia_pkg::BIT_EXT_FLAG])
      else $error("extended flag missed an event");
   a_code_flag_kept: assert property (@(posedge i_clk) disable iff (i_rst)
      (s.cause[sia_pkg::BIT_CODE_FLAG] && !i_ch0_rd) |=> s.cause[sia_pkg::BIT_CODE_FLAG])
      else $error("code flag cleared without channel-0 read");
   a_cause_rd_keeps: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_cause_rd && s.cause[sia_pkg::BIT_EXT_FLAG] && !i_ext_rd)
      |=> s.cause[sia_pkg::BIT_EXT_FLAG])
      else $error("cause read cleared extended flag");
   // hidden pending bits are those set in the state but absent from the view
   a_masked_pending: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_cause_rd && (s.cause & ~s.cause_view) != 8'h00)
      |=> ((s.cause & $past(s.cause & ~s.cause_view)) == $past(s.cause & ~s.cause_view)))
      else $error("masked pending event lost on read");
   a_ext_rd_clear: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ext_rd && ext_set == 8'h00) |=> !s.cause[sia_pkg::BIT_EXT_FLAG])
      else $error("extended read left flag set");
   a_change_bits_clr: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ch0_rd && !ch0_new) |=> !s.ch0_chg)
      else $error("channel-0 change bit survived read");
endmodule

// ===== bench/sia_host.sv
// sia_host: host that masks all sources, then restores its mask.
// assumes i_go is a one-cycle strobe; i_hold sets how slowly it restores.
module sia_host
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_go,
   input wire logic [3:0] i_hold,
   input wire logic [7:0] i_mask,
   output logic [7:0] o_mask
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt;
   // mask-all gap gives an edge-triggered controller a fresh edge
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         cnt <= '0;
      else if (i_go)
         cnt <= i_hold;
      else if (cnt != '0)
         cnt <= cnt - 4'h1;
   end
   assign o_mask = (cnt != '0) ? sia_pkg::MASK_ALL : i_mask;
endmodule

// ===== bench/sia_core_bench.sv
// sia_core_bench: directed tests of the interrupt aggregator.
// assumes a pull-up on the request pin and a free-running data clock.
module sia_core_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, data_clock_line = 0, tm = 0, sqe = 0, c1e = 0, go = 0;
   logic crd = 0, erd = 0, c0rd = 0, sqrd = 0, c1rd = 0, mrd = 0;
   logic mrx = 0, mhs = 0, mtx = 0, mval = 0, macked = 0, mend = 0, monitor_aborted = 0;
   logic [7:0] muser = '0, xevt = '0, mbyte = '0, mask, cause, ext, mdata;
   logic [5:0] src = '0;
   logic [3:0] sq = '0, c0 = '0, c1 = '0, hold = 4'hF, sqv, c1v, mst;
   logic [6:0] v0;
   logic ack, req_o, req_oe;
   int n_mismatch = 0;
   int cmp_count = 0;
   // open drain: released line reads high through the pull-up
   wire irq_n = req_oe ? req_o : 1'h1;

   sia_host i_host (.i_clk(clk), .i_rst(rst), .i_go(go), .i_hold(hold),
      .i_mask(muser), .o_mask(mask));
   sia_core i_dut (.i_clk(clk), .i_rst(rst), .i_data_clock_line(data_clock_line), .i_mask(mask),
      .i_src_evt(src), .i_ext_evt(xevt), .i_cause_rd(crd), .i_ext_rd(erd),
      .i_ch0_rd(c0rd), .i_sq_rd(sqrd), .i_ch1_rd(c1rd), .i_sq_code(sq),
      .i_ch0_code(c0), .i_ch1_code(c1), .i_terminal_mode(tm),
      .i_sq_change_enable(sqe), .i_ch1_change_enable(c1e), .i_mon_rx_enable(mrx),
      .i_mon_hs_control(mhs), .i_mon_tx_enable(mtx), .i_mon_tx_valid_bit(mval),
      .i_mon_byte(mbyte), .i_mon_end(mend), .i_mon_acked(macked),
      .i_mon_aborted(monitor_aborted), .i_mon_rd(mrd), .o_cause_status_reg(cause),
      .o_extended_cause_reg(ext), .o_code_receive_reg0(v0), .o_sq_receive_reg(sqv),
      .o_code_receive_reg1(c1v), .o_mon_data(mdata), .o_mon_status(mst),
      .o_monitor_rx_ack_bit(ack), .o_int_req_n_o(req_o), .o_int_req_n_oe(req_oe));

   initial forever #20 clk = ~clk;
   initial forever
   begin
      repeat (4) @(negedge clk);
      data_clock_line = ~data_clock_line;
   end

   task automatic conclude;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // one-cycle read strobe, then time for the views to settle
   task automatic rd(ref logic s);
      s = 1'h1;
      tick(1);
      s = 1'h0;
      tick(3);
   endtask

   task automatic wreq(input logic exp);
      int k = 0;
      while (irq_n !== exp && k < 20)
      begin
         tick(1);
         k++;
      end
      chk(irq_n, exp);
   endtask

   initial
   begin
      repeat (4000) @(posedge clk);
      n_mismatch++;
      conclude();
   end

   initial
   begin
      tick(12);
      rst = 0;
      tick(2);
      chk(cause, 8'h00);
      chk(irq_n, 1'h1);
      src = 6'h01;
      tick(1);
      src = '0;
      tick(2);
      chk(cause, 8'h02);
      wreq(0);
      rd(crd);
      chk(cause, 8'h00);
      wreq(1);
      src = 6'h01;
      tick(3);
      crd = 1'h1;
      tick(1);
      src = '0;
      crd = 1'h0;
      tick(2);
      chk(cause, 8'h02);
      rd(crd);
      $display("end basic");
      muser = 8'h02;
      tick(2);
      src = 6'h01;
      tick(1);
      src = '0;
      tick(2);
      chk(cause, 8'h00);
      rd(crd);
      tick(8);
      chk(irq_n, 1'h1);
      muser = '0;
      tick(3);
      chk(cause, 8'h02);
      wreq(0);
      rd(crd);
      wreq(1);
      $display("end mask");
      muser = 8'h01;
      tick(2);
      xevt = 8'h08;
      tick(1);
      xevt = '0;
      tick(12);
      chk(ext, 8'h08);
      chk(irq_n, 1'h1);
      muser = '0;
      tick(3);
      chk(cause, 8'h01);
      rd(crd);
      chk(cause, 8'h01);
      rd(erd);
      chk(ext, 8'h00);
      chk(cause, 8'h00);
      $display("end extended");
      c0 = 4'h5;
      tick(4);
      chk(v0, 7'h25);
      chk(cause, 8'h04);
      c0 = 4'h6;
      tick(2);
      c0 = 4'h9;
      tick(2);
      rd(crd);
      chk(cause, 8'h04);
      chk(v0, 7'h25);
      rd(c0rd);
      tick(2);
      chk(v0, 7'h29);
      chk(cause, 8'h04);
      rd(c0rd);
      chk(v0, 7'h09);
      chk(cause, 8'h00);
      wreq(1);
      c1e = 1'h1;
      c1 = 4'h3;
      sq = 4'h7;
      tick(6);
      chk(v0, 7'h09);
      sqe = 1'h1;
      tick(6);
      chk(v0, 7'h49);
      chk(sqv, 4'h7);
      rd(sqrd);
      rd(c0rd);
      tm = 1'h1;
      c1 = 4'h4;
      tick(6);
      chk(v0[4], 1'h1);
      chk(c1v, 4'h3);
      muser = 8'h04;
      rd(c1rd);
      chk(c1v, 4'h4);
      rd(c0rd);
      $display("end codes");
      mval = 1'h1;
      tick(2);
      mbyte = 8'h3C;
      mval = 1'h0;
      tick(3);
      chk(mst, 4'h0);
      mrx = 1'h1;
      mhs = 1'h1;
      mval = 1'h1;
      tick(2);
      mbyte = 8'hA5;
      mval = 1'h0;
      tick(2);
      chk(mdata, 8'hA5);
      chk(mst, 4'h1);
      chk(ack, 1'h0);
      tick(2);
      chk(ext[2], 1'h1);
      macked = 1'h1;
      tick(1);
      macked = 1'h0;
      tick(2);
      chk(mst, 4'h1);
      mtx = 1'h1;
      macked = 1'h1;
      tick(1);
      macked = 1'h0;
      tick(2);
      chk(mst, 4'h5);
      mend = 1'h1;
      monitor_aborted = 1'h1;
      tick(1);
      mend = 1'h0;
      monitor_aborted = 1'h0;
      tick(2);
      chk(mst, 4'hF);
      rd(mrd);
      // handshake control off: only the first byte of a packet is flagged
      mhs = 1'h0;
      mval = 1'h1;
      tick(2);
      mbyte = 8'h5A;
      mval = 1'h0;
      tick(2);
      chk(mst, 4'h1);
      chk(mdata, 8'h5A);
      chk(ack, 1'h1);
      rd(mrd);
      mval = 1'h1;
      tick(2);
      mbyte = 8'hC3;
      mval = 1'h0;
      tick(2);
      chk(mst, 4'h0);
      chk(mdata, 8'h5A);
      mend = 1'h1;
      tick(1);
      mend = 1'h0;
      tick(2);
      chk(mst, 4'h0);
      mval = 1'h1;
      rd(mrd);
      rd(erd);
      chk(cause[0], 1'h0);
      wreq(1);
      $display("end monitor");
      src = 6'h02;
      tick(1);
      src = '0;
      wreq(0);
      go = 1'h1;
      tick(1);
      go = 1'h0;
      wreq(1);
      wreq(0);
      rd(crd);
      wreq(1);
      $display("end service");
      conclude();
   end
endmodule
